// ---- dpm_defines.svh ----
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

`define DPM_CLK_NS        10
`define DPM_SETUP_NS      20
`define DPM_ACCESS_NS     80
`define DPM_RECOVER_NS    10
`define DPM_SETUP_CYC     ((`DPM_SETUP_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_ACCESS_CYC    ((`DPM_ACCESS_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_RECOVER_CYC   ((`DPM_RECOVER_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)

`define DPM_OFS_CTRL      8'h00
`define DPM_OFS_LCMD      8'h04
`define DPM_OFS_LWDATA    8'h08
`define DPM_OFS_LSTAT     8'h0C
`define DPM_OFS_RCMD      8'h10
`define DPM_OFS_RWDATA    8'h14
`define DPM_OFS_RSTAT     8'h18

`define DPM_CTRL_MASTER   0
`define DPM_CTRL_TIE_L    1
`define DPM_CTRL_TIE_R    2
`define DPM_CTRL_SEEN     3
`define DPM_CMD_WRITE     16
`define DPM_CMD_TOKEN     17
`define DPM_ST_BUSY       16
`define DPM_ST_BLOCKED    17
`define DPM_ST_IRQ        18
`define DPM_ST_COLL       19

`define DPM_CTRL_RESET    3'h7
`define DPM_MBOX_LEFT     14'h3FFE
`define DPM_MBOX_RIGHT    14'h3FFF

`endif

// ---- dpm_pkg.sv ----
package dpm_pkg;

    typedef struct packed {
        logic        port_select_n;
        logic        write_strobe_n;
        logic        output_drive_enable_n;
        logic        token_space_select_n;
        logic [13:0] addr;
        logic [15:0] data_out;
        logic        data_oe;
    } dpm_pins_type;

    typedef struct packed {
        logic        write;
        logic        token;
        logic [13:0] addr;
        logic [15:0] wdata;
    } dpm_cmd_type;

    typedef struct packed {
        logic [15:0] rdata;
        logic        busy;
        logic        blocked;
        logic        irq;
        logic        coll_ok;
    } dpm_stat_type;

    typedef enum logic [1:0] {
        DPM_IDLE,
        DPM_SETUP,
        DPM_ACTIVE,
        DPM_RECOVER
    } dpm_state_type;

endpackage : dpm_pkg

// ---- dpm_port_seq.sv ----
`timescale 1ns/1ns
`include "dpm_defines.svh"

module dpm_port_seq
    import dpm_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         start,
    input  wire dpm_cmd_type  cmd,
    input  wire logic         master,
    input  wire logic         tie,
    input  wire logic [15:0]  data_in,
    input  wire logic         irq_n_in,
    input  wire logic         coll_in,
    output dpm_pins_type      pins,
    output dpm_stat_type      stat
);

    logic [17:0]   sync1_reg;
    logic [17:0]   sync2_reg;
    dpm_state_type state_reg, state_next;
    logic [3:0]    cnt_reg, cnt_next;
    dpm_cmd_type   cmd_reg, cmd_next;
    dpm_pins_type  pins_reg, pins_next;
    dpm_stat_type  stat_reg, stat_next;
    logic          coll_ok;

    // Pins come from the other clock-less world
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 18'h3_FFFF;
            sync2_reg <= 18'h3_FFFF;
        end else begin
            sync1_reg <= {data_in, irq_n_in, coll_in};
            sync2_reg <= sync1_reg;
        end
    end

    // Slave mode: our own tie level is what the device sees
    assign coll_ok = master ? sync2_reg[0] : tie;

    always_comb begin
        state_next        = state_reg;
        cnt_next          = cnt_reg;
        cmd_next          = cmd_reg;
        pins_next         = pins_reg;
        stat_next         = stat_reg;
        stat_next.irq     = ~sync2_reg[1];
        stat_next.coll_ok = coll_ok;
        unique case (state_reg)
            DPM_IDLE: begin
                stat_next.busy = 1'b0;
                if (start) begin
                    cmd_next                        = cmd;
                    state_next                      = DPM_SETUP;
                    cnt_next                        = 4'(`DPM_SETUP_CYC);
                    stat_next.busy                  = 1'b1;
                    stat_next.blocked               = 1'b0;
                    pins_next.addr                  = cmd.addr;
                    pins_next.port_select_n         = cmd.token;
                    pins_next.token_space_select_n  = ~cmd.token;
                    pins_next.data_out              = cmd.wdata;
                    pins_next.data_oe               = cmd.write;
                end
            end
            DPM_SETUP: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    state_next = DPM_ACTIVE;
                    cnt_next   = 4'(`DPM_ACCESS_CYC);
                    if (cmd_reg.write) begin
                        pins_next.write_strobe_n = 1'b0;
                    end else begin
                        pins_next.output_drive_enable_n = 1'b0;
                    end
                end
            end
            DPM_ACTIVE: begin
                // In master mode, stretch the pulse while flagged so the write completes after release; slave mode keeps counting
                if (!coll_ok) begin
                    if (cmd_reg.write) begin
                        stat_next.blocked = 1'b1;
                    end
                    if (!master) begin
                        cnt_next = cnt_reg - 4'h1;
                    end
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
                if (cnt_next == 4'h0) begin
                    state_next                      = DPM_RECOVER;
                    cnt_next                        = 4'(`DPM_RECOVER_CYC);
                    pins_next.write_strobe_n        = 1'b1;
                    // Dropping the enable lets a polled token value refresh
                    pins_next.output_drive_enable_n = 1'b1;
                    if (!cmd_reg.write) begin
                        stat_next.rdata = sync2_reg[17:2];
                    end
                end
            end
            DPM_RECOVER: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    state_next                     = DPM_IDLE;
                    pins_next.port_select_n        = 1'b1;
                    pins_next.token_space_select_n = 1'b1;
                    pins_next.data_oe              = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DPM_IDLE;
            cnt_reg   <= 4'h0;
            cmd_reg   <= '0;
            pins_reg  <= '{port_select_n: 1'b1, write_strobe_n: 1'b1, output_drive_enable_n: 1'b1,
                           token_space_select_n: 1'b1, addr: 14'h0000, data_out: 16'h0000, data_oe: 1'b0};
            stat_reg  <= '{rdata: 16'h0000, busy: 1'b0, blocked: 1'b0, irq: 1'b0, coll_ok: 1'b1};
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            cmd_reg   <= cmd_next;
            pins_reg  <= pins_next;
            stat_reg  <= stat_next;
        end
    end

    assign pins = pins_reg;
    assign stat = stat_reg;

endmodule : dpm_port_seq

// ---- dpm_host_ctrl.sv ----
// How it works
// - In slave mode we drive the flag inputs high, or low to block.
// - Either collision flag low may be treated as an illegal-access event.
// - Depth cascades AND the collision flags externally.
// - Token access: port select high, token space select low.
`timescale 1ns/1ns
`include "dpm_defines.svh"

module dpm_host_ctrl
    import dpm_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    output logic              hierarchy_select,
    output dpm_pins_type      left_pins,
    input  wire logic [15:0]  left_data_in,
    input  wire logic         left_mailbox_irq,
    input  wire logic         left_collision_flag_in,
    output logic              left_collision_flag_out,
    output logic              left_collision_flag_oe,
    output dpm_pins_type      right_pins,
    input  wire logic [15:0]  right_data_in,
    input  wire logic         right_mailbox_irq,
    input  wire logic         right_collision_flag_in,
    output logic              right_collision_flag_out,
    output logic              right_collision_flag_oe
);

    logic [2:0]   ctrl_reg, ctrl_next;
    logic         seen_reg, seen_next;
    logic [15:0]  lwdata_reg, lwdata_next;
    logic [15:0]  rwdata_reg, rwdata_next;
    logic         lstart_reg, lstart_next;
    logic         rstart_reg, rstart_next;
    dpm_cmd_type  lcmd_reg, lcmd_next;
    dpm_cmd_type  rcmd_reg, rcmd_next;
    logic [31:0]  prdata_reg, prdata_next;
    logic         pready_reg, pready_next;
    logic         pslverr_reg, pslverr_next;
    logic         cout_l_reg, cout_l_next;
    logic         cout_r_reg, cout_r_next;
    logic         coe_reg, coe_next;
    dpm_stat_type lstat;
    dpm_stat_type rstat;
    logic [7:0]   ofs;
    logic         setup;
    logic         wr_done;
    logic         master;

    assign ofs     = paddr[7:0];
    assign setup   = psel && !penable;
    assign wr_done = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign master  = ctrl_reg[`DPM_CTRL_MASTER];

    dpm_port_seq u_left (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (lstart_reg),
        .cmd      (lcmd_reg),
        .master   (master),
        .tie      (ctrl_reg[`DPM_CTRL_TIE_L]),
        .data_in  (left_data_in),
        .irq_n_in (left_mailbox_irq),
        .coll_in  (left_collision_flag_in),
        .pins     (left_pins),
        .stat     (lstat)
    );

    dpm_port_seq u_right (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (rstart_reg),
        .cmd      (rcmd_reg),
        .master   (master),
        .tie      (ctrl_reg[`DPM_CTRL_TIE_R]),
        .data_in  (right_data_in),
        .irq_n_in (right_mailbox_irq),
        .coll_in  (right_collision_flag_in),
        .pins     (right_pins),
        .stat     (rstat)
    );

    function automatic logic [31:0] stat_word(input dpm_stat_type s);
        logic [31:0] w;
        w                  = {16'h0000, s.rdata};
        w[`DPM_ST_BUSY]    = s.busy;
        w[`DPM_ST_BLOCKED] = s.blocked;
        w[`DPM_ST_IRQ]     = s.irq;
        w[`DPM_ST_COLL]    = s.coll_ok;
        return w;
    endfunction : stat_word

    function automatic dpm_cmd_type make_cmd(input logic [31:0] d, input logic [15:0] wd);
        dpm_cmd_type c;
        c.write = d[`DPM_CMD_WRITE];
        c.token = d[`DPM_CMD_TOKEN];
        c.addr  = d[13:0];
        c.wdata = wd;
        return c;
    endfunction : make_cmd

    always_comb begin
        ctrl_next    = ctrl_reg;
        seen_next    = seen_reg;
        lwdata_next  = lwdata_reg;
        rwdata_next  = rwdata_reg;
        lcmd_next    = lcmd_reg;
        rcmd_next    = rcmd_reg;
        lstart_next  = 1'b0;
        rstart_next  = 1'b0;
        prdata_next  = prdata_reg;
        // Error only stands alongside pready
        pslverr_next = 1'b0;
        pready_next  = setup;
        if (setup) begin
            prdata_next  = 32'h0000_0000;
            pslverr_next = 1'b0;
            if (paddr[31:8] != 24'h00_0000) begin
                pslverr_next = 1'b1;
            end else begin
                unique case (ofs)
                    `DPM_OFS_CTRL:   prdata_next = {28'h000_0000, seen_reg, ctrl_reg};
                    `DPM_OFS_LCMD:   pslverr_next = pwrite && lstat.busy;
                    `DPM_OFS_LWDATA: prdata_next = {16'h0000, lwdata_reg};
                    `DPM_OFS_LSTAT:  prdata_next = stat_word(lstat);
                    `DPM_OFS_RCMD:   pslverr_next = pwrite && rstat.busy;
                    `DPM_OFS_RWDATA: prdata_next = {16'h0000, rwdata_reg};
                    `DPM_OFS_RSTAT:  prdata_next = stat_word(rstat);
                    default:         pslverr_next = 1'b1;
                endcase
            end
        end
        if (wr_done) begin
            unique case (ofs)
                `DPM_OFS_CTRL: begin
                    ctrl_next = pwdata[2:0];
                    if (pwdata[`DPM_CTRL_SEEN]) begin
                        seen_next = 1'b0;
                    end
                end
                `DPM_OFS_LCMD: begin
                    lcmd_next   = make_cmd(pwdata, lwdata_reg);
                    lstart_next = 1'b1;
                end
                `DPM_OFS_RCMD: begin
                    rcmd_next   = make_cmd(pwdata, rwdata_reg);
                    rstart_next = 1'b1;
                end
                `DPM_OFS_LWDATA: lwdata_next = pwdata[15:0];
                `DPM_OFS_RWDATA: rwdata_next = pwdata[15:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        if (master && (!lstat.coll_ok || !rstat.coll_ok)) begin
            seen_next = 1'b1;
        end
        coe_next    = ~master;
        cout_l_next = ctrl_reg[`DPM_CTRL_TIE_L];
        cout_r_next = ctrl_reg[`DPM_CTRL_TIE_R];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= `DPM_CTRL_RESET;
            seen_reg    <= 1'b0;
            lwdata_reg  <= 16'h0000;
            rwdata_reg  <= 16'h0000;
            lcmd_reg    <= '0;
            rcmd_reg    <= '0;
            lstart_reg  <= 1'b0;
            rstart_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            cout_l_reg  <= 1'b1;
            cout_r_reg  <= 1'b1;
            coe_reg     <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            seen_reg    <= seen_next;
            lwdata_reg  <= lwdata_next;
            rwdata_reg  <= rwdata_next;
            lcmd_reg    <= lcmd_next;
            rcmd_reg    <= rcmd_next;
            lstart_reg  <= lstart_next;
            rstart_reg  <= rstart_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            cout_l_reg  <= cout_l_next;
            cout_r_reg  <= cout_r_next;
            coe_reg     <= coe_next;
        end
    end

    assign prdata                   = prdata_reg;
    assign pready                   = pready_reg;
    assign pslverr                  = pslverr_reg;
    assign hierarchy_select         = ctrl_reg[`DPM_CTRL_MASTER];
    assign left_collision_flag_out  = cout_l_reg;
    assign right_collision_flag_out = cout_r_reg;
    assign left_collision_flag_oe   = coe_reg;
    assign right_collision_flag_oe  = coe_reg;

endmodule : dpm_host_ctrl

// ---- dpm_dev_model.sv ----
`timescale 1ns/1ns
module dpm_dev_model
    import dpm_pkg::*;
(
    input  wire dpm_pins_type      left_pins,
    input  wire dpm_pins_type      right_pins,
    input  wire logic              hier,
    input  wire logic [1:0]        coll_wire,
    output logic      [1:0]        busy_n,
    output logic      [1:0]        irq_n,
    output logic      [1:0][15:0]  dq
);
    dpm_pins_type  pn [2];
    logic [15:0]   mem [16384];
    logic [15:0]   val [2];
    logic [1:0]    owner [8];
    logic [1:0]    pend [8];
    time           t_chg [2];
    logic          match;
    assign pn[0] = left_pins;
    assign pn[1] = right_pins;
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        foreach (owner[i]) owner[i] = 2'h0;
        foreach (pend[i]) pend[i] = 2'h0;
        irq_n = 2'h3;
        val[0] = 16'h0000;
        val[1] = 16'h0000;
    end
    // Select and address only, direction ignored
    assign match = !pn[0].port_select_n && !pn[1].port_select_n && pn[0].addr == pn[1].addr;
    // Later settler flagged; a tie goes right so never both
    assign busy_n[0] = !(hier && match && t_chg[0] > t_chg[1]);
    assign busy_n[1] = !(hier && match && t_chg[0] <= t_chg[1]);
    task automatic sem_wr(input int p, input logic [2:0] i, input logic d);
        if (!d) begin
            if (owner[i] == 2'h0) owner[i] = 2'(p + 1);
            else if (owner[i] != 2'(p + 1)) pend[i][p] = 1'b1;
        end else if (owner[i] == 2'(p + 1)) begin
            owner[i] = pend[i][1 - p] ? 2'(2 - p) : 2'h0;
            pend[i][1 - p] = 1'b0;
        end else pend[i][p] = 1'b0;
    endtask : sem_wr
    for (genvar p = 0; p < 2; p++) begin : g_port
        always @(pn[p].port_select_n or pn[p].addr) t_chg[p] = $time;
        // Released bus shows the inverse, never the stale value
        assign dq[p] = (!pn[p].output_drive_enable_n && pn[p].write_strobe_n) ? val[p] : ~val[p];
        always @(posedge pn[p].write_strobe_n) begin
            if (!pn[p].port_select_n && coll_wire[p]) begin
                mem[pn[p].addr] = pn[p].data_out;
                if (pn[p].addr == (p ? 14'h3FFE : 14'h3FFF)) irq_n[1 - p] = 1'b0;
            end
            if (!pn[p].token_space_select_n && pn[p].port_select_n) sem_wr(p, pn[p].addr[2:0], pn[p].data_out[0]);
        end
        always @(negedge pn[p].output_drive_enable_n) begin
            if (!pn[p].port_select_n) begin
                val[p] = mem[pn[p].addr];
                if (pn[p].addr == (p ? 14'h3FFF : 14'h3FFE) && coll_wire[p]) irq_n[p] = 1'b1;
            end
            // Latched at enable, held until released
            if (!pn[p].token_space_select_n && pn[p].port_select_n) val[p] = {16{owner[pn[p].addr[2:0]] != 2'(p + 1)}};
        end
    end
endmodule : dpm_dev_model

// ---- dpm_host_ctrl_assertions.sv ----
`timescale 1ns/1ns
module dpm_host_ctrl_assertions
    import dpm_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pready,
    input  wire logic          pslverr,
    input  wire logic          hierarchy_select,
    input  wire dpm_pins_type  left_pins,
    input  wire dpm_pins_type  right_pins,
    input  wire logic          right_collision_flag_in,
    input  wire logic          left_collision_flag_oe,
    input  wire logic          right_collision_flag_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    flag_dir_a: assert property ($stable(hierarchy_select) |-> left_collision_flag_oe != hierarchy_select
        && right_collision_flag_oe != hierarchy_select) else $error("collision pin direction wrong");
    token_sel_a: assert property ($fell(left_pins.token_space_select_n) |-> left_pins.port_select_n)
        else $error("token access with array selected");
    strobe_gap_a: assert property ($fell(left_pins.port_select_n)
        |-> ##2 (!left_pins.write_strobe_n || !left_pins.output_drive_enable_n)) else $error("strobe not two after select");
    no_fight_a: assert property (left_pins.data_oe |-> left_pins.output_drive_enable_n) else $error("data fight");
    release_a: assert property ($rose(left_pins.output_drive_enable_n)
        |=> left_pins.port_select_n && left_pins.token_space_select_n) else $error("select kept after read");
    addr_hold_a: assert property (!right_pins.write_strobe_n |-> $stable(right_pins.addr) && $stable(right_pins.data_out))
        else $error("address moved in strobe");
    read_len_a: assert property ($fell(left_pins.output_drive_enable_n) && !hierarchy_select
        |-> !left_pins.output_drive_enable_n [*8] ##1 left_pins.output_drive_enable_n) else $error("read strobe length");
    cover property (hierarchy_select && !right_collision_flag_in);
    cover property ($fell(left_pins.token_space_select_n));
    cover property (!hierarchy_select && !right_pins.write_strobe_n);
endmodule : dpm_host_ctrl_assertions
bind dpm_host_ctrl dpm_host_ctrl_assertions dpm_host_ctrl_assertions_i (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .hierarchy_select, .left_pins, .right_pins, .right_collision_flag_in, .left_collision_flag_oe,
    .right_collision_flag_oe);

// ---- tb.sv ----
`timescale 1ns/1ns
module tb
    import dpm_pkg::*;
;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, hier, err_seen;
    logic [31:0]         paddr, pwdata, prdata, rd, st;
    dpm_pins_type        lp, rp;
    logic [1:0]          busy_n, irq_n, oe, cout, cwire;
    logic [1:0][15:0]    dq;
    int                  errors, num_checks;
    localparam logic [9:0] SP = 10'h0D2, SD = 10'h2B4, SL = 10'h2EC, SR = 10'h3B3;
    // Master drives the pin from the device, slave from the host
    assign cwire[0] = hier ? busy_n[0] : (oe[0] ? cout[0] : 1'b1);
    assign cwire[1] = hier ? busy_n[1] : (oe[1] ? cout[1] : 1'b1);
    dpm_host_ctrl dpm_host_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hierarchy_select(hier), .left_pins(lp), .left_data_in(dq[0]), .left_mailbox_irq(irq_n[0]),
        .left_collision_flag_in(cwire[0]), .left_collision_flag_out(cout[0]), .left_collision_flag_oe(oe[0]),
        .right_pins(rp), .right_data_in(dq[1]), .right_mailbox_irq(irq_n[1]),
        .right_collision_flag_in(cwire[1]), .right_collision_flag_out(cout[1]), .right_collision_flag_oe(oe[1]));
    dpm_dev_model dpm_dev_model_i (.left_pins(lp), .right_pins(rp), .hier(hier), .coll_wire(cwire),
        .busy_n(busy_n), .irq_n(irq_n), .dq(dq));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            test_done();
        end
        r = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    // Status of port p until its access is over
    task automatic wait_idle(input int p, output logic [31:0] s);
        int n;
        n = 0;
        do begin
            xfer(1'b0, 32'(p * 12 + 12), 32'h0000_0000, s);
            n++;
        end while (s[16] !== 1'b0 && n < 40);
        if (n >= 40) begin
            errors++;
            test_done();
        end
    endtask : wait_idle
    task automatic acc(input int p, input logic w, input logic t, input logic [13:0] a, input logic [15:0] d,
                       output logic [31:0] s);
        xfer(1'b1, 32'(p * 12 + 8), {16'h0000, d}, s);
        xfer(1'b1, 32'(p * 12 + 4), {14'h0000, t, w, 2'h0, a}, s);
        wait_idle(p, s);
    endtask : acc
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        errors = 0;
        num_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("master", hier, 1);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        chk("ctrl", rd, 32'h0000_0007);
        xfer(1'b0, 32'h0000_001C, 32'h0000_0000, rd);
        chk("unmapped", {err_seen, rd[30:0]}, 32'h8000_0000);
        acc(0, 1'b1, 1'b0, 14'h0010, 16'h0123, st);
        acc(1, 1'b0, 1'b0, 14'h0010, 16'h0000, st);
        chk("plain", st[15:0], 16'h0123);
        for (int p = 0; p < 2; p++) begin
            acc(p, 1'b1, 1'b0, p ? 14'h3FFE : 14'h3FFF, 16'hA5A0 + 16'(p), st);
            xfer(1'b0, 32'(24 - p * 12), 32'h0000_0000, st);
            chk("irq set", st[18], 1);
            acc(1 - p, 1'b0, 1'b0, p ? 14'h3FFE : 14'h3FFF, 16'h0000, st);
            chk("box", st[15:0], 16'hA5A0 + 16'(p));
            xfer(1'b0, 32'(24 - p * 12), 32'h0000_0000, st);
            chk("irq clr", st[18], 0);
        end
        // Only the three low address bits pick a latch
        for (int k = 0; k < 10; k++) begin
            acc(SP[k] ? 1 : 0, 1'b1, 1'b1, 14'h3FF5, {15'h0000, SD[k]}, st);
            acc(0, 1'b0, 1'b1, 14'h0005, 16'h0000, st);
            chk("sem left", st[15:0], {16{SL[k]}});
            acc(1, 1'b0, 1'b1, 14'h3FFD, 16'h0000, st);
            chk("sem right", st[15:0], {16{SR[k]}});
        end
        // Overlapping writes to one word: right settles later
        xfer(1'b1, 32'h0000_0008, 32'h0000_1111, rd);
        xfer(1'b1, 32'h0000_0014, 32'h0000_2222, rd);
        xfer(1'b1, 32'h0000_0004, 32'h0001_0040, rd);
        xfer(1'b1, 32'h0000_0010, 32'h0001_0040, rd);
        wait_idle(1, st);
        chk("r stalled", st[17], 1);
        wait_idle(0, st);
        chk("l free", st[17], 0);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        chk("seen", rd[3], 1);
        acc(0, 1'b0, 1'b0, 14'h0040, 16'h0000, st);
        chk("later", st[15:0], 16'h2222);
        xfer(1'b1, 32'h0000_0000, 32'h0000_000F, rd);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        chk("w1c", rd, 32'h0000_0007);
        // Slave mode, right port tied low
        xfer(1'b1, 32'h0000_0000, 32'h0000_0002, rd);
        chk("slave", hier, 0);
        acc(1, 1'b1, 1'b0, 14'h3FFE, 16'h5555, st);
        chk("r tied", st[19:17], 3'h1);
        xfer(1'b0, 32'h0000_000C, 32'h0000_0000, st);
        chk("no irq", st[18], 0);
        acc(0, 1'b0, 1'b0, 14'h3FFE, 16'h0000, st);
        chk("kept", st[15:0], 16'hA5A1);
        acc(0, 1'b1, 1'b0, 14'h0041, 16'hBEEF, st);
        acc(1, 1'b0, 1'b0, 14'h0041, 16'h0000, st);
        chk("l tied", st[15:0], 16'hBEEF);
        // Reset in mid-run, from slave mode
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset hier", hier, 1);
        chk("reset oe", oe, 2'h0);
        chk("reset tie", cout, 2'h3);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        chk("reset ctrl", rd, 32'h0000_0007);
        test_done();
    end
endmodule : tb
